//--- src/dur_update_ctrl.sv
// Update, mask, reset and reference control of a 16-channel converter
`timescale 1ns/1ps
`default_nettype none
`include "dur_defs.svh"
module dur_update_ctrl
    import dur_pkg::*;
#(
    parameter int          CHANNELS   = 16,
    parameter logic [15:0] RESET_CODE = `DUR_CODE_ZERO,
    parameter int          POR_CYCLES = `DUR_POR_CYCLES
)
(
    input  wire logic         SYS_CLK_IN,
    input  wire logic         NRST_IN,
    input  wire logic         LINK_CLK_IN,
    input  wire logic         SYNC_N_IN,
    input  wire logic         SDI_IN,
    input  wire logic         LOAD_STROBE_N_IN,
    input  wire logic         RESET_N_IN,
    output logic [16*16-1:0]  DAC_CODE_OUT,
    output logic [16*16-1:0]  INPUT_CODE_OUT,
    output logic [15:0]       LOAD_MASK_OUT,
    output logic              REF_ENABLE_OUT,
    output logic              READY_OUT
);
    import dur_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Frame receiver
    dur_frame_t frame;
    logic       frame_valid;

    dur_link_rx dur_link_rx_i (
        .LINK_CLK_IN     (LINK_CLK_IN),
        .SYNC_N_IN       (SYNC_N_IN),
        .SDI_IN          (SDI_IN),
        .SYS_CLK_IN      (SYS_CLK_IN),
        .NRST_IN         (NRST_IN),
        .FRAME_OUT       (frame),
        .FRAME_VALID_OUT (frame_valid)
    );

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic ld_s1_q;
    logic ld_s2_q;
    logic ld_s3_q;
    logic rs_s1_q;
    logic rs_s2_q;

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!NRST_IN)
        begin
            ld_s1_q <= 1'b1;
            ld_s2_q <= 1'b1;
            ld_s3_q <= 1'b1;
            rs_s1_q <= 1'b1;
            rs_s2_q <= 1'b1;
        end
        else
        begin
            ld_s1_q <= LOAD_STROBE_N_IN;
            ld_s2_q <= ld_s1_q;
            ld_s3_q <= ld_s2_q;
            rs_s1_q <= RESET_N_IN;
            rs_s2_q <= rs_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Power-on sequence
    dur_state_t  state_q;
    logic [15:0] por_cnt_q;

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!NRST_IN)
        begin
            state_q   <= DUR_ST_POR;
            por_cnt_q <= 16'h0000;
        end
        else
        begin
            case (state_q)
                DUR_ST_POR:
                begin
                    if (por_cnt_q == 16'(POR_CYCLES - 1))
                    begin
                        state_q <= DUR_ST_HOLD;
                    end
                    else
                    begin
                        por_cnt_q <= 16'(por_cnt_q + 16'h0001);
                    end
                end
                DUR_ST_HOLD:
                begin
                    if (rs_s2_q)
                    begin
                        state_q <= DUR_ST_RUN;
                    end
                end
                DUR_ST_RUN:
                begin
                    state_q <= DUR_ST_RUN;
                end
                default:
                begin
                    state_q <= DUR_ST_POR;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Qualified controls
    logic running;
    logic pin_reset;
    logic ld_low;
    logic ld_fall;
    logic sw_reset;
    logic [3:0] cmd;

    assign running   = (state_q == DUR_ST_RUN);
    assign pin_reset = running && !rs_s2_q;
    assign ld_low    = running && !ld_s2_q;
    assign ld_fall   = running && ld_s3_q && !ld_s2_q;
    assign cmd       = frame.cmd;
    assign sw_reset  = running && frame_valid && cmd == `DUR_CMD_SWRST
                       && frame.addr == `DUR_SWRST_ADDR
                       && frame.data == `DUR_SWRST_KEY;

    function automatic logic addr_hit(input logic [3:0] a, input int ch);
        addr_hit = (int'(a) == ch);
    endfunction

    ////////////////////////////////////////////////////////////////
    // Mask and reference control
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!NRST_IN || sw_reset)
        begin
            LOAD_MASK_OUT  <= `DUR_MASK_RESET;
            REF_ENABLE_OUT <= ~`DUR_REF_RESET;
        end
        else if (running && frame_valid)
        begin
            if (cmd == `DUR_CMD_MASK)
            begin
                LOAD_MASK_OUT <= frame.data;
            end
            if (cmd == `DUR_CMD_REFCTL)
            begin
                REF_ENABLE_OUT <= ~frame.data[`DUR_REFCTL_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Per-channel input and DAC registers
    logic [15:0] in_q  [CHANNELS];
    logic [15:0] dac_q [CHANNELS];

    always_ff @(posedge SYS_CLK_IN)
    begin
        for (int ch = 0; ch < CHANNELS; ch++)
        begin
            if (!NRST_IN || sw_reset || pin_reset || !running)
            begin
                in_q[ch]  <= RESET_CODE;
                dac_q[ch] <= RESET_CODE;
            end
            else
            begin
                if (frame_valid && addr_hit(frame.addr, ch)
                    && (cmd == `DUR_CMD_WR_IN || cmd == `DUR_CMD_WR_UPD))
                begin
                    in_q[ch] <= frame.data;
                end
                if (frame_valid && addr_hit(frame.addr, ch) && cmd == `DUR_CMD_WR_UPD)
                begin
                    dac_q[ch] <= frame.data;
                end
                else if (frame_valid && addr_hit(frame.addr, ch) && cmd == `DUR_CMD_UPD)
                begin
                    dac_q[ch] <= in_q[ch];
                end
                else if (frame_valid && addr_hit(frame.addr, ch)
                         && cmd == `DUR_CMD_WR_IN && ld_low)
                begin
                    dac_q[ch] <= frame.data;
                end
                else if (ld_fall && !LOAD_MASK_OUT[ch])
                begin
                    dac_q[ch] <= in_q[ch];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Outputs
    always_comb
    begin
        for (int ch = 0; ch < 16; ch++)
        begin
            DAC_CODE_OUT[ch*16 +: 16]   = (ch < CHANNELS) ? dac_q[ch] : 16'h0000;
            INPUT_CODE_OUT[ch*16 +: 16] = (ch < CHANNELS) ? in_q[ch] : 16'h0000;
        end
    end

    assign READY_OUT = running;
endmodule
`default_nettype wire

//--- src/dur_defs.svh
// Constants for the converter update and reset control
`ifndef DUR_DEFS_SVH
`define DUR_DEFS_SVH
`define DUR_FRAME_BITS   24
`define DUR_CMD_MSB      23
`define DUR_CMD_LSB      20
`define DUR_ADDR_MSB     19
`define DUR_ADDR_LSB     16
`define DUR_DATA_MSB     15
`define DUR_DATA_LSB     0
`define DUR_CMD_NOP      4'h0
`define DUR_CMD_WR_IN    4'h1
`define DUR_CMD_UPD      4'h2
`define DUR_CMD_WR_UPD   4'h3
`define DUR_CMD_MASK     4'h5
`define DUR_CMD_SWRST    4'h6
`define DUR_CMD_REFCTL   4'h7
`define DUR_SWRST_ADDR   4'h0
`define DUR_SWRST_KEY    16'h1234
`define DUR_CODE_ZERO    16'h0000
`define DUR_CODE_MID     16'h8000
`define DUR_MASK_RESET   16'h0000
`define DUR_REF_RESET    1'b0
`define DUR_REFCTL_BIT   0
`define DUR_POR_NS       1000
`define DUR_CLK_MHZ      125
`define DUR_POR_CYCLES   ((`DUR_POR_NS * `DUR_CLK_MHZ + 999) / 1000)
`endif

//--- src/dur_pkg.sv
// Types for the converter update and reset control
package dur_pkg;
    typedef struct packed {
        logic [3:0]  cmd;
        logic [3:0]  addr;
        logic [15:0] data;
    } dur_frame_t;

    typedef enum logic [2:0] {
        DUR_ST_POR  = 3'h1,
        DUR_ST_HOLD = 3'h2,
        DUR_ST_RUN  = 3'h4
    } dur_state_t;
endpackage

//--- src/dur_link_rx.sv
// Serial frame receiver on the link clock with word handover
`timescale 1ns/1ps
`default_nettype none
`include "dur_defs.svh"
module dur_link_rx
    import dur_pkg::*;
(
    input  wire logic       LINK_CLK_IN,
    input  wire logic       SYNC_N_IN,
    input  wire logic       SDI_IN,
    input  wire logic       SYS_CLK_IN,
    input  wire logic       NRST_IN,
    output dur_pkg::dur_frame_t FRAME_OUT,
    output logic            FRAME_VALID_OUT
);
    import dur_pkg::*;

    ////////////////////////////////////////////////////////////////
    // Link domain shift register and bit count
    logic [23:0] shift_q;
    logic [4:0]  count_q;
    logic [23:0] word_q;
    logic        tog_q;
    logic        clr_tog_q;
    logic        clr_seen_q;

    // Frame start marker, toggled on each sync fall
    always_ff @(negedge SYNC_N_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            clr_tog_q <= 1'b0;
        end
        else
        begin
            clr_tog_q <= ~clr_tog_q;
        end
    end

    // Count restarts at the first link edge of each frame
    always_ff @(posedge LINK_CLK_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            count_q    <= 5'h00;
            clr_seen_q <= 1'b0;
        end
        else if (!SYNC_N_IN)
        begin
            clr_seen_q <= clr_tog_q;
            if (clr_seen_q != clr_tog_q)
            begin
                count_q <= 5'h01;
            end
            else if (count_q != 5'h1F)
            begin
                count_q <= 5'(count_q + 5'h01);
            end
        end
    end

    always_ff @(posedge LINK_CLK_IN)
    begin
        if (!SYNC_N_IN)
        begin
            shift_q <= {shift_q[22:0], SDI_IN};
        end
    end

    ////////////////////////////////////////////////////////////////
    // Word captured on sync rising edge, only if exactly 24 bits
    always_ff @(posedge SYNC_N_IN or negedge NRST_IN)
    begin
        if (!NRST_IN)
        begin
            word_q <= 24'h000000;
            tog_q  <= 1'b0;
        end
        else if (count_q == 5'(`DUR_FRAME_BITS))
        begin
            word_q <= shift_q;
            tog_q  <= ~tog_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // System domain toggle synchroniser
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!NRST_IN)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end
        else
        begin
            sync1_q <= tog_q;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!NRST_IN)
        begin
            FRAME_OUT       <= '0;
            FRAME_VALID_OUT <= 1'b0;
        end
        else
        begin
            FRAME_VALID_OUT <= sync2_q ^ sync3_q;
            if (sync2_q ^ sync3_q)
            begin
                FRAME_OUT <= dur_frame_t'(word_q);
            end
        end
    end
endmodule
`default_nettype wire

//--- tb/dur_update_ctrl_monitor.sv
// Port checker for the converter update and reset control
`timescale 1ns/1ps
`default_nettype none
module dur_update_ctrl_monitor
#(
    parameter logic [15:0] RESET_CODE = 16'h0000
)
(
    input wire logic         SYS_CLK_IN,
    input wire logic         NRST_IN,
    input wire logic         SYNC_N_IN,
    input wire logic         LOAD_STROBE_N_IN,
    input wire logic         RESET_N_IN,
    input wire logic [255:0] DAC_CODE_OUT,
    input wire logic [255:0] INPUT_CODE_OUT,
    input wire logic [15:0]  LOAD_MASK_OUT,
    input wire logic         REF_ENABLE_OUT,
    input wire logic         READY_OUT
);
    default clocking dc @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (!NRST_IN);
    ////////////////////////////////////////
    property p_ref_on;
        $rose(READY_OUT) |-> REF_ENABLE_OUT;
    endproperty
    a_ref_on: assert property (p_ref_on) else $error("ref off at ready");
    property p_codes_start;
        $rose(READY_OUT) |-> DAC_CODE_OUT == {16{RESET_CODE}};
    endproperty
    a_codes_start: assert property (p_codes_start) else $error("codes not reset at ready");
    property p_pin_clears;
        (!RESET_N_IN) [*4] |=> DAC_CODE_OUT == {16{RESET_CODE}};
    endproperty
    a_pin_clears: assert property (p_pin_clears) else $error("reset pin did not clear");
    property p_pin_hold;
        (!RESET_N_IN) [*4] ##1 (RESET_N_IN && SYNC_N_IN && LOAD_STROBE_N_IN) [*8]
            |-> DAC_CODE_OUT == {16{RESET_CODE}};
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("code moved after pin release");
    property p_ready_pin;
        !READY_OUT && !RESET_N_IN |=> !READY_OUT;
    endproperty
    a_ready_pin: assert property (p_ready_pin) else $error("ready with pin low");
    property p_strobe_upd;
        $fell(LOAD_STROBE_N_IN) && READY_OUT && LOAD_MASK_OUT == 16'h0000
            ##1 (SYNC_N_IN && RESET_N_IN) [*6] |-> DAC_CODE_OUT == INPUT_CODE_OUT;
    endproperty
    a_strobe_upd: assert property (p_strobe_upd) else $error("strobe fall missed");
    property p_ref_quiet;
        (SYNC_N_IN && RESET_N_IN) [*8] |=> $stable(REF_ENABLE_OUT);
    endproperty
    a_ref_quiet: assert property (p_ref_quiet) else $error("ref moved without frame");
    property p_mask_quiet;
        (SYNC_N_IN && RESET_N_IN) [*8] |=> $stable(LOAD_MASK_OUT);
    endproperty
    a_mask_quiet: assert property (p_mask_quiet) else $error("mask moved without frame");
endmodule
`default_nettype wire

//--- tb/dur_host.sv
// Serial master model sending frames to the converter control
`timescale 1ns/1ps
`default_nettype none
module dur_host
    import dur_pkg::*;
(
    output logic LINK_CLK_OUT,
    output logic SYNC_N_OUT,
    output logic SDI_OUT
);
    initial
    begin
        LINK_CLK_OUT = 1'h0;
        SYNC_N_OUT   = 1'h1;
        SDI_OUT      = 1'h0;
    end
    // Top nbits of a word, MSB first, clock idle between frames
    task automatic send(input dur_pkg::dur_frame_t f, input int nbits);
        #3;
        SYNC_N_OUT = 1'h0;
        for (int i = 23; i >= 24 - nbits; i--)
        begin
            SDI_OUT = f[i];
            #6 LINK_CLK_OUT = 1'h1;
            #6 LINK_CLK_OUT = 1'h0;
        end
        #6 SYNC_N_OUT = 1'h1;
        SDI_OUT = ~SDI_OUT;
    endtask
endmodule
`default_nettype wire

//--- tb/dur_update_ctrl_test.sv
// Self-checking bench for the converter update and reset control
`timescale 1ns/1ps
`default_nettype none
module dur_update_ctrl_test;
    import dur_pkg::*;
    localparam logic [15:0] RC = 16'h8000;
    logic         sys_clk, nrst, strobe_n, pin_n, link_clk, sync_n, sdi, ref_en, ready;
    logic [255:0] dac, inp;
    logic [15:0]  mask;
    int           bad_count = 0;
    int           checks = 0;
    int           cycles = 0;
    // Frame, strobe, channel, input, DAC, ref, mask
    logic [77:0]  rows [17] = '{
        {24'h131111, 1'h1, 4'h3, 16'h1111, 16'h8000, 1'h1, 16'h0000},
        {24'h23ABCD, 1'h1, 4'h3, 16'h1111, 16'h1111, 1'h1, 16'h0000},
        {24'h132222, 1'h0, 4'h3, 16'h2222, 16'h2222, 1'h1, 16'h0000},
        {24'h353333, 1'h1, 4'h5, 16'h3333, 16'h3333, 1'h1, 16'h0000},
        {24'h5A0008, 1'h1, 4'h3, 16'h2222, 16'h2222, 1'h1, 16'h0008},
        {24'h136666, 1'h1, 4'h3, 16'h6666, 16'h2222, 1'h1, 16'h0008},
        {24'h157777, 1'h1, 4'h5, 16'h7777, 16'h3333, 1'h1, 16'h0008},
        {24'h000000, 1'h0, 4'h5, 16'h7777, 16'h7777, 1'h1, 16'h0008},
        {24'h000000, 1'h0, 4'h3, 16'h6666, 16'h2222, 1'h1, 16'h0008},
        {24'h139999, 1'h0, 4'h3, 16'h9999, 16'h9999, 1'h1, 16'h0008},
        {24'h500000, 1'h1, 4'h3, 16'h9999, 16'h9999, 1'h1, 16'h0000},
        {24'h7FFFF9, 1'h1, 4'h0, 16'h8000, 16'h8000, 1'h0, 16'h0000},
        {24'h7FFFF8, 1'h1, 4'h0, 16'h8000, 16'h8000, 1'h1, 16'h0000},
        {24'hF3ABCD, 1'h1, 4'h3, 16'h9999, 16'h9999, 1'h1, 16'h0000},
        {24'h601235, 1'h1, 4'h3, 16'h9999, 16'h9999, 1'h1, 16'h0000},
        {24'h611234, 1'h1, 4'h3, 16'h9999, 16'h9999, 1'h1, 16'h0000},
        {24'h601234, 1'h1, 4'h3, 16'h8000, 16'h8000, 1'h1, 16'h0000}};
    dur_host dur_host_i (.LINK_CLK_OUT(link_clk), .SYNC_N_OUT(sync_n), .SDI_OUT(sdi));
    dur_update_ctrl #(.RESET_CODE(RC), .POR_CYCLES(4)) dur_update_ctrl_i (.SYS_CLK_IN(sys_clk), .NRST_IN(nrst),
        .LINK_CLK_IN(link_clk), .SYNC_N_IN(sync_n), .SDI_IN(sdi), .LOAD_STROBE_N_IN(strobe_n), .RESET_N_IN(pin_n),
        .DAC_CODE_OUT(dac), .INPUT_CODE_OUT(inp), .LOAD_MASK_OUT(mask), .REF_ENABLE_OUT(ref_en), .READY_OUT(ready));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wait_ready();
        for (int n = 0; n < 100 && ready !== 1'h1; n++)
            @(posedge sys_clk);
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        sys_clk = 1'h0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            tally_and_finish();
        end
    end
    initial
    begin
        dur_frame_t  f;
        logic        s, er;
        logic [3:0]  ch;
        logic [15:0] ei, ed, em;
        nrst = 1'h0;
        strobe_n = 1'h1;
        pin_n = 1'h1;
        tick(12);
        chk(ready, 32'h0);
        chk(dac[255:240], RC);
        chk(inp[15:0], RC);
        chk(mask, 32'h0);
        chk(ref_en, 32'h1);
        nrst <= 1'h1;
        wait_ready();
        chk(ready, 32'h1);
        chk(ref_en, 32'h1);
        $display("reset test done");
        for (int i = 0; i < 17; i++)
        begin
            {f, s, ch, ei, ed, er, em} = rows[i];
            strobe_n <= s;
            tick(8);
            dur_host_i.send(f, 24);
            tick(10);
            chk(inp[ch*16+:16], ei);
            chk(dac[ch*16+:16], ed);
            chk(ref_en, er);
            chk(mask, em);
            $display("row %0d done", i);
        end
        dur_host_i.send(24'h33AAAA, 24);
        tick(10);
        chk(dac[63:48], 32'hAAAA);
        pin_n <= 1'h0;
        tick(6);
        chk(dac[63:48], RC);
        dur_host_i.send(24'h33BBBB, 24);
        tick(10);
        chk(dac[63:48], RC);
        pin_n <= 1'h1;
        tick(30);
        chk(dac[63:48], RC);
        dur_host_i.send(24'h33CCCC, 24);
        tick(10);
        chk(dac[63:48], 32'hCCCC);
        dur_host_i.send(24'h33DDDD, 23);
        tick(10);
        chk(dac[63:48], 32'hCCCC);
        chk(inp[63:48], 32'hCCCC);
        $display("reset pin test done");
        nrst <= 1'h0;
        pin_n <= 1'h0;
        tick(12);
        nrst <= 1'h1;
        strobe_n <= 1'h0;
        tick(30);
        chk(ready, 32'h0);
        pin_n <= 1'h1;
        strobe_n <= 1'h1;
        wait_ready();
        chk(ready, 32'h1);
        chk(dac[63:48], RC);
        $display("power-up hold test done");
        tally_and_finish();
    end
endmodule
bind dur_update_ctrl dur_update_ctrl_monitor #(.RESET_CODE(RESET_CODE)) dur_update_ctrl_monitor_i (.SYS_CLK_IN,
    .NRST_IN, .SYNC_N_IN, .LOAD_STROBE_N_IN, .RESET_N_IN, .DAC_CODE_OUT, .INPUT_CODE_OUT, .LOAD_MASK_OUT,
    .REF_ENABLE_OUT, .READY_OUT);
`default_nettype wire
